// ---- msw_params.svh ----
// constants for the mode, supply and watchdog control registers
`ifndef MSW_PARAMS_SVH
`define MSW_PARAMS_SVH
// register addresses, 7 bits
`define MSW_ADDR_MSC 7'h01
`define MSW_ADDR_HW 7'h02
`define MSW_ADDR_WD 7'h03
// reset values
`define MSW_MSC_POR 8'h00
`define MSW_HW_POR 8'h00
`define MSW_WD_POR 8'h14
// writable bit masks, reserved bits clear
`define MSW_HW_WMASK 8'hFB
`define MSW_WD_WMASK 8'hF7
// bits kept by soft reset in the hardware config register
`define MSW_HW_SOFT_KEEP 8'h88
// bits kept on restart, and bits forced set in the watchdog register
`define MSW_MSC_RST_KEEP 8'h23
`define MSW_HW_RST_KEEP 8'hD9
`define MSW_WD_RST_KEEP 8'hB0
`define MSW_WD_RST_SET 8'h04
// field positions
`define MSW_MODE_HI 7
`define MSW_MODE_LO 6
`define MSW_REG2_HI 4
`define MSW_REG2_LO 3
`define MSW_REG3_EN 5
`define MSW_OV_ACT 2
`define MSW_RT_HI 1
`define MSW_RT_LO 0
`define MSW_V_SEL 7
`define MSW_SR_OPT 6
`define MSW_FO_SW 5
`define MSW_UV_KEEP 4
`define MSW_LSHARE 3
`define MSW_LS_STOP 1
`define MSW_CFG 0
`define MSW_WD_CSUM 7
`define MSW_WD_STOPD 6
`define MSW_WD_TYPE 5
`define MSW_WD_BUSWK 4
`define MSW_WD_PER_HI 2
`define MSW_WD_PER_LO 0
`define MSW_WD_PER_RSVD 3'h7
`define MSW_REG2_OFF 2'h0
// reset output low time after a soft reset, clock cycles
`define MSW_RSTOUT_LOW_CYC 5'h10
// serial frame layout
`define MSW_FRAME_BITS 5'h10
`define MSW_ADDR_BITS 5'h08
// frame field positions once all 16 bits are in
`define MSW_FR_ACC 7
`define MSW_FR_ADDR_HI 6
`define MSW_FR_ADDR_LO 0
`define MSW_FR_DATA_HI 15
`define MSW_FR_DATA_LO 8
// top address bit after the first byte
`define MSW_FR_PEEK_HI 14
`endif

// ---- msw_pkg.sv ----
// types for the mode, supply and watchdog control registers
package msw_pkg;
  typedef enum logic [1:0] {
    MSW_NORMAL = 2'h0,
    MSW_SLEEP = 2'h1,
    MSW_STOP = 2'h2,
    MSW_SOFTRST = 2'h3
  } msw_mode_t;

  typedef struct packed {
    logic sckPrev;
    logic csPrev;
    logic [4:0] bitCnt;
    logic loaded;
    logic [15:0] rx;
    logic [7:0] tx;
    logic sdo;
    logic done;
  } msw_frame_t;

  typedef struct packed {
    logic [7:0] msc;
    logic [7:0] hw;
    logic [7:0] wd;
    logic [4:0] rstOutCnt;
    logic rstOutLow;
    logic foOut;
    logic ovSet;
    logic ovAct;
    logic softPulse;
    logic parityOk;
  } msw_regs_t;
endpackage

// ---- msw_frame_rx.sv ----
// 16-bit serial frame receiver and readback shifter
`timescale 1ns/1ps
`include "msw_params.svh"
module msw_frame_rx (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiSdi,
  input wire logic [7:0] rdData,
  output logic spiSdo,
  output logic [6:0] peekAddr,
  output logic frameDone,
  output logic frameWrite,
  output logic [6:0] frameAddr,
  output logic [7:0] frameData
);
  msw_pkg::msw_frame_t q, d;

  // shift on sck edges while selected, lsb first
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.sckPrev = spiSck;
    d.csPrev = spiCsN;
    if (spiCsN) begin
      d.bitCnt = 5'h00;
      d.loaded = 1'b0;
      d.tx = 8'h00;
      d.sdo = 1'b0;
      d.done = !q.csPrev && (q.bitCnt == `MSW_FRAME_BITS);
    end else begin
      if (spiSck && !q.sckPrev && q.bitCnt != `MSW_FRAME_BITS) begin
        d.rx = {spiSdi, q.rx[15:1]};
        d.bitCnt = q.bitCnt + 5'h01;
      end
      // readback taken before any write lands
      if (q.bitCnt == `MSW_ADDR_BITS && !q.loaded) begin
        d.tx = rdData;
        d.loaded = 1'b1;
      end
      if (!spiSck && q.sckPrev) begin
        d.sdo = q.tx[0];
        d.tx = {1'b0, q.tx[7:1]};
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // frame fields: address, access bit, data byte
  assign spiSdo = q.sdo;
  assign peekAddr = q.rx[`MSW_FR_PEEK_HI:`MSW_FR_DATA_LO];
  assign frameDone = q.done;
  assign frameWrite = q.rx[`MSW_FR_ACC];
  assign frameAddr = q.rx[`MSW_FR_ADDR_HI:`MSW_FR_ADDR_LO];
  assign frameData = q.rx[`MSW_FR_DATA_HI:`MSW_FR_DATA_LO];
endmodule

// ---- msw_ctrl_regs.sv ----
// mode, supply and watchdog control register bank
`timescale 1ns/1ps
`include "msw_params.svh"
module msw_ctrl_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiSdi,
  input wire logic restartEnter,
  input wire logic overTemperature,
  input wire logic mainOvEvent,
  input wire logic failureFlag,
  output logic spiSdo,
  output logic [7:0] modeSupplyControl,
  output logic [7:0] hardwareConfigControl,
  output logic [7:0] watchdogControl,
  output logic failureOutputs,
  output logic resetOutputLow,
  output logic mainOvFlagSet,
  output logic mainOvActionReq,
  output logic softResetPulse,
  output logic wdParityOk
);
  msw_pkg::msw_regs_t q, d;
  logic [6:0] peekAddr;
  logic [7:0] rdData;
  logic frameDone;
  logic frameWrite;
  logic [6:0] frameAddr;
  logic [7:0] frameData;
  logic wrMsc;
  logic wrHw;
  logic wrWd;
  logic softTrig;
  logic sleepBlocked;

  // register readback by address
  function automatic logic [7:0] readReg(input logic [6:0] a,
                                         input msw_pkg::msw_regs_t r);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `MSW_ADDR_MSC: v = r.msc;
      `MSW_ADDR_HW: v = r.hw;
      `MSW_ADDR_WD: v = r.wd;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // readback for the frame in progress
  assign rdData = readReg(peekAddr, q);

  msw_frame_rx uFrame (
    .clk(clk),
    .reset_n(reset_n),
    .spiCsN(spiCsN),
    .spiSck(spiSck),
    .spiSdi(spiSdi),
    .rdData(rdData),
    .spiSdo(spiSdo),
    .peekAddr(peekAddr),
    .frameDone(frameDone),
    .frameWrite(frameWrite),
    .frameAddr(frameAddr),
    .frameData(frameData)
  );

  // write decode, access bit set means write
  always_comb begin
    wrMsc = frameDone && frameWrite && frameAddr == `MSW_ADDR_MSC;
    wrHw = frameDone && frameWrite && frameAddr == `MSW_ADDR_HW;
    wrWd = frameDone && frameWrite && frameAddr == `MSW_ADDR_WD;
    softTrig = wrMsc && frameData[`MSW_MODE_HI:`MSW_MODE_LO] ==
               msw_pkg::MSW_SOFTRST;
    sleepBlocked = frameData[`MSW_MODE_HI:`MSW_MODE_LO] ==
                   msw_pkg::MSW_SLEEP &&
                   q.msc[`MSW_MODE_HI:`MSW_MODE_LO] == msw_pkg::MSW_STOP;
  end

  // next state: writes, then soft reset, over-temperature, restart
  always_comb begin
    d = q;
    d.softPulse = 1'b0;
    // mode, regulator, overvoltage and threshold fields
    if (wrMsc) begin
      d.msc = frameData;
      if (sleepBlocked) begin
        d.msc[`MSW_MODE_HI:`MSW_MODE_LO] = msw_pkg::MSW_STOP;
      end
    end
    // options only store; reserved bit dropped
    if (wrHw) begin
      d.hw = frameData & `MSW_HW_WMASK;
    end
    // watchdog settings stored, reserved bit dropped; reserved period code keeps the old period
    if (wrWd) begin
      d.wd = frameData & `MSW_WD_WMASK;
      if (frameData[`MSW_WD_PER_HI:`MSW_WD_PER_LO] == `MSW_WD_PER_RSVD) begin
        d.wd[`MSW_WD_PER_HI:`MSW_WD_PER_LO] =
          q.wd[`MSW_WD_PER_HI:`MSW_WD_PER_LO];
      end
    end
    // soft reset: mode and watchdog to power-on values, hardware config keeps only kept bits
    if (softTrig) begin
      d.softPulse = 1'b1;
      d.msc = `MSW_MSC_POR;
      d.hw = q.hw & `MSW_HW_SOFT_KEEP;
      d.wd = `MSW_WD_POR;
      if (!q.hw[`MSW_SR_OPT]) begin
        d.rstOutCnt = `MSW_RSTOUT_LOW_CYC;
      end
    end
    // reset output low timer
    if (!softTrig || q.hw[`MSW_SR_OPT]) begin
      if (q.rstOutCnt != 5'h00) begin
        d.rstOutCnt = q.rstOutCnt - 5'h01;
      end
    end
    // over-temperature turns the second regulator off
    if (overTemperature) begin
      d.msc[`MSW_REG2_HI:`MSW_REG2_LO] = `MSW_REG2_OFF;
    end
    // restart values: mode normal, regulator off, sw failure bit cleared
    if (restartEnter) begin
      d.msc = q.msc & `MSW_MSC_RST_KEEP;
      d.hw = q.hw & `MSW_HW_RST_KEEP;
      d.wd = (q.wd & `MSW_WD_RST_KEEP) | `MSW_WD_RST_SET;
    end
    d.rstOutLow = d.rstOutCnt != 5'h00;
    // failure outputs: software bit or a pending failure
    d.foOut = d.hw[`MSW_FO_SW] | failureFlag;
    // overvoltage flag always, action only when enabled
    d.ovSet = mainOvEvent;
    d.ovAct = mainOvEvent & q.msc[`MSW_OV_ACT];
    // even parity over the whole watchdog byte
    d.parityOk = ~^d.wd;
  end

  // state register, power-on values
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{msc: `MSW_MSC_POR, hw: `MSW_HW_POR, wd: `MSW_WD_POR,
             rstOutCnt: 5'h00, rstOutLow: 1'b0, foOut: 1'b0,
             ovSet: 1'b0, ovAct: 1'b0, softPulse: 1'b0,
             parityOk: ~^`MSW_WD_POR}; // status of the reset value
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign modeSupplyControl = q.msc;
  assign hardwareConfigControl = q.hw;
  assign watchdogControl = q.wd;
  assign failureOutputs = q.foOut;
  assign resetOutputLow = q.rstOutLow;
  assign mainOvFlagSet = q.ovSet;
  assign mainOvActionReq = q.ovAct;
  assign softResetPulse = q.softPulse;
  assign wdParityOk = q.parityOk;

  // checks on the register behaviour
  property p_sleepFromStop;
    @(posedge clk) disable iff (!reset_n)
    wrMsc && sleepBlocked && !restartEnter |=>
      modeSupplyControl[`MSW_MODE_HI:`MSW_MODE_LO] == msw_pkg::MSW_STOP;
  endproperty
  a_sleepFromStop: assert property (p_sleepFromStop)
    else $error("sleep entered from stop");

  property p_restartMode;
    @(posedge clk) disable iff (!reset_n)
    restartEnter |=>
      modeSupplyControl[`MSW_MODE_HI:`MSW_MODE_LO] == msw_pkg::MSW_NORMAL &&
      modeSupplyControl[`MSW_REG2_HI:`MSW_REG2_LO] == `MSW_REG2_OFF;
  endproperty
  a_restartMode: assert property (p_restartMode)
    else $error("restart did not force normal mode and regulator off");

  property p_hotReg2Off;
    @(posedge clk) disable iff (!reset_n)
    overTemperature |=>
      modeSupplyControl[`MSW_REG2_HI:`MSW_REG2_LO] == `MSW_REG2_OFF;
  endproperty
  a_hotReg2Off: assert property (p_hotReg2Off)
    else $error("second regulator left on after over-temperature");

  property p_ovFlag;
    @(posedge clk) disable iff (!reset_n)
    mainOvEvent |=> mainOvFlagSet &&
      mainOvActionReq == $past(modeSupplyControl[`MSW_OV_ACT]);
  endproperty
  a_ovFlag: assert property (p_ovFlag)
    else $error("overvoltage flag or action wrong");

  property p_foHold;
    @(posedge clk) disable iff (!reset_n)
    failureFlag |=> failureOutputs;
  endproperty
  a_foHold: assert property (p_foHold)
    else $error("failure outputs released while failure pending");

  property p_foRestart;
    @(posedge clk) disable iff (!reset_n)
    restartEnter && !failureFlag |=>
      !failureOutputs && !hardwareConfigControl[`MSW_FO_SW];
  endproperty
  a_foRestart: assert property (p_foRestart)
    else $error("software failure activation survived restart");

  property p_softRo;
    @(posedge clk) disable iff (!reset_n)
    softTrig && !hardwareConfigControl[`MSW_SR_OPT] |=>
      softResetPulse ##1 resetOutputLow [*8];
  endproperty
  a_softRo: assert property (p_softRo)
    else $error("reset output not held low after soft reset");

  property p_softKeep;
    @(posedge clk) disable iff (!reset_n)
    softTrig && !restartEnter |=>
      hardwareConfigControl ==
        ($past(hardwareConfigControl) & `MSW_HW_SOFT_KEEP) &&
      watchdogControl == `MSW_WD_POR;
  endproperty
  a_softKeep: assert property (p_softKeep)
    else $error("soft reset values wrong");

  property p_parity;
    @(posedge clk) disable iff (!reset_n)
    wdParityOk == ~^watchdogControl;
  endproperty
  a_parity: assert property (p_parity)
    else $error("watchdog parity status wrong");

  property p_reserved;
    @(posedge clk) disable iff (!reset_n)
    (hardwareConfigControl & ~`MSW_HW_WMASK) == 8'h00 &&
    (watchdogControl & ~`MSW_WD_WMASK) == 8'h00 &&
    watchdogControl[`MSW_WD_PER_HI:`MSW_WD_PER_LO] != `MSW_WD_PER_RSVD;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit or period code stored");

  // soft reset clears the mode register and pulses once
  property p_softMode;
    @(posedge clk) disable iff (!reset_n)
    softTrig && !restartEnter |=>
      softResetPulse && modeSupplyControl == `MSW_MSC_POR;
  endproperty
  a_softMode: assert property (p_softMode)
    else $error("soft reset did not clear the mode register");

  // option set: soft reset leaves the reset output alone
  property p_roQuiet;
    @(posedge clk) disable iff (!reset_n)
    softTrig && hardwareConfigControl[`MSW_SR_OPT] && !resetOutputLow |=>
      !resetOutputLow;
  endproperty
  a_roQuiet: assert property (p_roQuiet)
    else $error("reset output pulled low although option set");

  // option bits land as written, reserved bit dropped
  property p_hwStore;
    @(posedge clk) disable iff (!reset_n)
    wrHw && !restartEnter |=>
      hardwareConfigControl == ($past(frameData) & `MSW_HW_WMASK);
  endproperty
  a_hwStore: assert property (p_hwStore)
    else $error("hardware config write not stored");

  // no overvoltage flag or action without an event
  property p_ovQuiet;
    @(posedge clk) disable iff (!reset_n)
    !mainOvEvent |=> !mainOvFlagSet && !mainOvActionReq;
  endproperty
  a_ovQuiet: assert property (p_ovQuiet)
    else $error("overvoltage flag without an event");

  // main scenarios
  c_softReset: cover property (@(posedge clk) disable iff (!reset_n)
    softTrig ##1 softResetPulse);
  c_sleepBlocked: cover property (@(posedge clk) disable iff (!reset_n)
    wrMsc && sleepBlocked);
  c_wdWrite: cover property (@(posedge clk) disable iff (!reset_n)
    wrWd ##1 wdParityOk);
  c_restart: cover property (@(posedge clk) disable iff (!reset_n)
    restartEnter && hardwareConfigControl[`MSW_FO_SW]);
  c_ovAction: cover property (@(posedge clk) disable iff (!reset_n)
    mainOvEvent ##1 mainOvActionReq);
endmodule

// ---- msw_host_model.sv ----
// host model that sends 16-bit serial frames to the control registers
`timescale 1ns/1ps
module msw_host_model (
  input wire logic clk,
  input wire logic spiSdo,
  output logic spiCsN,
  output logic spiSck,
  output logic spiSdi
);
  // idle: deselected, clock parked low
  initial begin
    spiCsN = 1'b1;
    spiSck = 1'b0;
    spiSdi = 1'b0;
  end

  // one frame, lsb first; each sck phase lasts 3 clocks
  task automatic frame(input logic [6:0] addr, input logic wr,
                       input logic [7:0] data, output logic [7:0] rb);
    logic [15:0] word;
    word = {data, wr, addr};
    rb = 8'h00;
    repeat (2) @(posedge clk);
    spiCsN <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      spiSdi <= word[i];
      repeat (3) @(posedge clk);
      if (i >= 8) rb[i-8] = spiSdo; // second byte carries readback
      spiSck <= 1'b1;
      repeat (3) @(posedge clk);
      spiSck <= 1'b0;
    end
    repeat (3) @(posedge clk);
    spiCsN <= 1'b1;
    spiSdi <= ~word[15]; // released line shows no stale bit
  endtask
endmodule

// ---- msw_ctrl_regs_tb.sv ----
// self-checking bench for the mode, supply and watchdog registers
`timescale 1ns/1ps
`include "msw_params.svh"
module msw_ctrl_regs_tb;
  logic clk;
  logic reset_n;
  logic restartEnter;
  logic overTemperature;
  logic mainOvEvent;
  logic failureFlag;
  logic spiCsN;
  logic spiSck;
  logic spiSdi;
  logic spiSdo;
  logic [7:0] msc;
  logic [7:0] hw;
  logic [7:0] wd;
  logic failureOutputs;
  logic resetOutputLow;
  logic mainOvFlagSet;
  logic mainOvActionReq;
  logic softResetPulse;
  logic wdParityOk;
  int errorCnt;
  int nTests;

  msw_ctrl_regs dut (
    .clk(clk),
    .reset_n(reset_n),
    .spiCsN(spiCsN),
    .spiSck(spiSck),
    .spiSdi(spiSdi),
    .restartEnter(restartEnter),
    .overTemperature(overTemperature),
    .mainOvEvent(mainOvEvent),
    .failureFlag(failureFlag),
    .spiSdo(spiSdo),
    .modeSupplyControl(msc),
    .hardwareConfigControl(hw),
    .watchdogControl(wd),
    .failureOutputs(failureOutputs),
    .resetOutputLow(resetOutputLow),
    .mainOvFlagSet(mainOvFlagSet),
    .mainOvActionReq(mainOvActionReq),
    .softResetPulse(softResetPulse),
    .wdParityOk(wdParityOk)
  );

  msw_host_model host (
    .clk(clk),
    .spiSdo(spiSdo),
    .spiCsN(spiCsN),
    .spiSck(spiSck),
    .spiSdi(spiSdi)
  );

  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chkRegs(input logic [7:0] m, h, w);
    chk(msc, m);
    chk(hw, h);
    chk(wd, w);
  endtask

  // write frame, readback must be the old value
  task automatic wr(input logic [6:0] a, input logic [7:0] d, old);
    logic [7:0] rb;
    host.frame(a, 1'b1, d, rb);
    chk(rb, old);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] rb;
    host.frame(a, 1'b0, 8'hA5, rb);
    chk(rb, exp);
    repeat (3) @(posedge clk);
    #1;
  endtask

  // mode codes, stop to sleep refusal, field codes, read-only frames
  task automatic tModes();
    logic [7:0] v;
    logic [7:0] prev;
    wr(7'h01, 8'h40, 8'h00);
    chk(msc, 8'h40);
    wr(7'h01, 8'h80, 8'h40);
    wr(7'h01, 8'h41, 8'h80);
    chk(msc, 8'h81);
    prev = 8'h81;
    for (int i = 0; i < 4; i++) begin
      v = {2'h0, i[0], i[1:0], i[1], i[1:0]};
      wr(7'h01, v, prev);
      chk(msc, v);
      prev = v;
    end
    rd(7'h01, prev);
    chk(msc, prev);
    rd(7'h10, 8'h00);
    wr(7'h01, 8'h00, prev);
  endtask

  // software and failure driven failure outputs
  task automatic tFail();
    wr(7'h02, 8'hFF, 8'h00);
    chk(hw, 8'hFB);
    chk({7'h0, failureOutputs}, 8'h01);
    @(posedge clk) failureFlag <= 1'b1;
    wr(7'h02, 8'hDB, 8'hFB);
    chk({7'h0, failureOutputs}, 8'h01);
    @(posedge clk) failureFlag <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, failureOutputs}, 8'h00);
    wr(7'h02, 8'h00, 8'hDB);
  endtask

  // period codes with even parity, reserved code, odd parity
  task automatic tWdog();
    logic [7:0] v;
    logic [7:0] prev;
    prev = 8'h14;
    for (int c = 0; c < 7; c++) begin
      v[6:0] = {4'h6, c[2:0]};
      v[7] = ^v[6:0];
      wr(7'h03, v, prev);
      chk(wd, v);
      chk({7'h0, wdParityOk}, 8'h01);
      prev = v;
    end
    wr(7'h03, 8'hFF, prev);
    chk(wd, 8'hF6);
    wr(7'h03, 8'h52, 8'hF6);
    chk(wd, 8'h52);
    chk({7'h0, wdParityOk}, 8'h00);
    wr(7'h03, 8'h14, 8'h52);
  endtask

  // soft reset through mode code 11
  task automatic tSoft(input logic [7:0] hOld, hSet, hExp, roExp);
    logic [7:0] rb;
    int pc;
    int rc;
    pc = 0;
    rc = 0;
    wr(7'h02, hSet, hOld);
    wr(7'h01, 8'h1F, 8'h00);
    host.frame(7'h01, 1'b1, 8'hDF, rb);
    chk(rb, 8'h1F);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (softResetPulse === 1'b1) pc++;
      if (resetOutputLow === 1'b1) rc++;
    end
    chk(pc[7:0], 8'h01);
    chk(rc[7:0], roExp);
    chkRegs(8'h00, hExp, 8'h14);
  endtask

  // restart, overvoltage and over-temperature events
  task automatic tEvents();
    wr(7'h01, 8'h9F, 8'h00);
    wr(7'h02, 8'hFB, 8'h08);
    wr(7'h03, 8'h71, 8'h14);
    @(posedge clk) restartEnter <= 1'b1;
    @(posedge clk) restartEnter <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chkRegs(8'h03, 8'hD9, 8'h34);
    chk({7'h0, failureOutputs}, 8'h00);
    wr(7'h01, 8'h18, 8'h03);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk) mainOvEvent <= 1'b1;
      @(posedge clk) mainOvEvent <= 1'b0;
      #1;
      chk({7'h0, mainOvFlagSet}, 8'h01);
      chk({7'h0, mainOvActionReq}, j[7:0]);
      @(posedge clk);
      #1;
      chk({7'h0, mainOvFlagSet}, 8'h00);
      if (j == 0) wr(7'h01, 8'h1C, 8'h18);
    end
    @(posedge clk) overTemperature <= 1'b1;
    @(posedge clk) overTemperature <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(msc, 8'h04);
  endtask

  // verdict and end of run
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    errorCnt++;
    closeOut();
  end

  // main sequence
  initial begin
    errorCnt = 0;
    nTests = 0;
    reset_n = 1'b0;
    restartEnter = 1'b0;
    overTemperature = 1'b0;
    mainOvEvent = 1'b0;
    failureFlag = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chkRegs(8'h00, 8'h00, 8'h14);
    chk({7'h0, wdParityOk}, 8'h01);
    tModes();
    tFail();
    tWdog();
    tSoft(8'h00, 8'h89, 8'h88, {3'h0, `MSW_RSTOUT_LOW_CYC});
    tSoft(8'h88, 8'h48, 8'h08, 8'h00);
    tEvents();
    closeOut();
  end
endmodule
